// File: pkg/btseq_pkg.sv
// Constants and types for the battery discharge test sequencer.
// Assumes a single 40 MHz clock and plain-port configuration.
// Behaviour
// - static mode limits discharge by configured maximum current and power
// - static mode applies resistance setting; a config value disables it
// - dynamic mode uses larger of two currents as upper level
// - dynamic upper level held for pulse time of 1 to 36000 s
// - dynamic lower level held for pause time 1 to 36000 s, then repeat
// - test stops when battery voltage reaches discharge voltage threshold
// - elapsed test time compared against maximum of 0 to 10 h
// - consumed charge compared against capacity limit up to 99999.99 Ah
// - time and capacity limits each have none, signal or stop action
// - limits and actions kept separately for static and dynamic modes
// - when logging enabled, one record per selected logging interval
// - capacity and energy update once per second only
// - log opens with header row of mode and set values
// - data rows hold voltage, current, power, Ah, Wh, ms timestamp
// - log marked available only after the test has stopped
// - running values and regulation mode presented on outputs
// - operator stop control ends the run at any time
// - alarm that switches off the input also stops the test
// - after automatic stop, restart refused until reconfiguration
// - static gives current, power or resistance; dynamic gives pulses
package btseq_pkg;
  // ==========================================================
  // timebase
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned TICK_MS       = 1;
  localparam int unsigned MS_CYCLES     = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned MS_PER_S      = 1000;
  localparam int unsigned DUR_MIN_S     = 1;
  localparam int unsigned DUR_MAX_S     = 36000;
  localparam int unsigned TIME_MAX_S    = 10 * 3600;
  // capacity limit in units of 0.01 Ah
  localparam int unsigned CAP_MAX_CAH   = 9_999_999;
  localparam logic [15:0] RES_OFF       = 16'h0000;
  // ==========================================================
  // logging interval codes: 0..9 = 100..1000 ms, 10 = 5 s, 11 = 10 s
  localparam logic [3:0]  LOG_5S_CODE   = 4'ha;
  localparam logic [3:0]  LOG_10S_CODE  = 4'hb;
  localparam int unsigned LOG_STEP_MS   = 100;
  // ==========================================================
  typedef enum logic [1:0] {BTSEQ_ACT_NONE, BTSEQ_ACT_SIGNAL,
                            BTSEQ_ACT_END, BTSEQ_ACT_RSVD} btseq_act_t;
  typedef enum logic [1:0] {BTSEQ_REG_CC, BTSEQ_REG_CP,
                            BTSEQ_REG_CR, BTSEQ_REG_OFF} btseq_reg_t;
  typedef enum logic [2:0] {BTSEQ_STOP_NONE, BTSEQ_STOP_MANUAL,
                            BTSEQ_STOP_TIME, BTSEQ_STOP_CAP,
                            BTSEQ_STOP_ALARM, BTSEQ_STOP_VOLT} btseq_why_t;
  // record kinds in the log stream
  localparam logic        REC_HEADER    = 1'b0;
  localparam logic        REC_DATA      = 1'b1;
endpackage : btseq_pkg

// File: hdl/btseq_skid.sv
// Two-entry buffer between record builder and log consumer.
// Assumes source and sink share mclk; sink may stall any time.
`timescale 1ns/100ps
module btseq_skid
  import btseq_pkg::*;
#(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         nrst,
  input  wire logic         ce,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  typedef struct packed {
    logic [1:0][W-1:0] mem;
    logic              rd;
    logic              wr;
    logic [1:0]        cnt;
  } btseq_skid_t;
  btseq_skid_t s_q, s_d;

  assign in_ready  = (s_q.cnt != 2'h2);
  assign out_valid = (s_q.cnt != 2'h0);
  assign out_data  = s_q.mem[s_q.rd];

  // next state: push and pop may happen in one cycle
  always_comb begin
    logic push;
    logic pop;
    push = in_valid && in_ready;
    pop  = out_valid && out_ready;
    s_d  = s_q;
    if (push) begin
      s_d.mem[s_q.wr] = in_data;
      s_d.wr          = ~s_q.wr;
    end
    if (pop) begin
      s_d.rd = ~s_q.rd;
    end
    if (push && !pop) begin
      s_d.cnt = s_q.cnt + 2'h1;
    end else if (pop && !push) begin
      s_d.cnt = s_q.cnt - 2'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end
endmodule // btseq_skid

// File: hdl/btseq_top.sv
// Battery discharge test sequencer: mode control, stop logic,
// charge and energy integration, and log record stream.
// Assumes measurements already scaled: current mA, power W, voltage mV.
`timescale 1ns/100ps
module btseq_top
  import btseq_pkg::*;
#(
  parameter int          IW   = 16,
  parameter int unsigned MS_N = MS_CYCLES,
  parameter int          RW   = 128
) (
  // clock, reset, enable
  input  wire logic          mclk,
  input  wire logic          nrst,
  input  wire logic          ce,
  // operator controls (start_pin and stop_pin asynchronous)
  input  wire logic          start_pin,
  input  wire logic          stop_pin,
  input  wire logic          config_done,
  input  wire logic          dyn_mode,
  // static settings
  input  wire logic [IW-1:0] st_current_max,
  input  wire logic [IW-1:0] st_power_max,
  input  wire logic [15:0]   st_resistance,
  // dynamic settings
  input  wire logic [IW-1:0] dy_current_a,
  input  wire logic [IW-1:0] dy_current_b,
  input  wire logic [IW-1:0] dy_power_max,
  input  wire logic [15:0]   dy_pulse_s,
  input  wire logic [15:0]   dy_pause_s,
  // per-mode limits and actions
  input  wire logic [IW-1:0] st_discharge_voltage_threshold,
  input  wire logic [15:0]   st_discharge_time_limit,
  input  wire logic [23:0]   st_discharge_capacity_limit,
  input  wire btseq_act_t    st_time_act,
  input  wire btseq_act_t    st_cap_act,
  input  wire logic [IW-1:0] dy_discharge_voltage_threshold,
  input  wire logic [15:0]   dy_discharge_time_limit,
  input  wire logic [23:0]   dy_discharge_capacity_limit,
  input  wire btseq_act_t    dy_time_act,
  input  wire btseq_act_t    dy_cap_act,
  // logging setup
  input  wire logic          log_en,
  input  wire logic [3:0]    log_interval,
  // measurements and alarms
  input  wire logic [IW-1:0] meas_voltage,
  input  wire logic [IW-1:0] meas_current,
  input  wire logic [IW-1:0] meas_power,
  input  wire logic          input_off_alarm,
  input  wire logic          over_temperature_alarm,
  // regulation outputs
  output logic               load_on,
  output logic [IW-1:0]      set_current,
  output logic [IW-1:0]      set_power,
  output logic [15:0]        set_resistance,
  output logic               res_reg_en,
  output btseq_reg_t         reg_mode,
  // status
  output logic               running,
  output logic               time_limit_msg,
  output logic               cap_limit_msg,
  output btseq_why_t         stop_cause,
  output logic               locked_out,
  output logic [31:0]        elapsed_ms,
  output logic [31:0]        used_mah_s,
  output logic [31:0]        used_wh_s,
  output logic [IW-1:0]      disp_voltage,
  output logic [IW-1:0]      disp_threshold,
  output logic               log_ready,
  // record stream
  output logic               rec_valid,
  input  wire logic          rec_ready,
  output logic [RW-1:0]      rec_data
);
  // ==========================================================
  // state
  typedef enum logic [1:0] {ST_IDLE, ST_HDR, ST_RUN} btseq_st_t;
  typedef struct packed {
    btseq_st_t  st;
    logic [2:0] start_s;
    logic [2:0] stop_s;
    logic       start_f;
    logic       stop_f;
    logic       dyn;
    logic       hi;
    logic [15:0] phase_s;
    logic [25:0] ms_cnt;
    logic [9:0]  ms_in_s;
    logic [31:0] ms;
    logic [31:0] secs;
    logic [48:0] mah_s; // covers the full capacity range in mA*ms
    logic [31:0] wh_s;
    logic [48:0] mah_pub;
    logic [31:0] wh_pub;
    logic [13:0] log_cnt;
    logic        tmsg;
    logic        cmsg;
    logic        lock;
    logic        logged;
    btseq_why_t  why;
  } btseq_top_t;
  btseq_top_t s_q, s_d;

  logic          push;
  logic          push_ok;
  logic [RW-1:0] rec_word;
  logic [IW-1:0] hi_cur, lo_cur;
  logic [IW-1:0] thr;
  logic [15:0]   tlim;
  logic [23:0]   clim;
  btseq_act_t    tact, cact;
  logic [13:0]   log_ms;

  // ==========================================================
  // per-mode selection keeps both setting sets independent
  assign thr  = s_q.dyn ? dy_discharge_voltage_threshold
                        : st_discharge_voltage_threshold;
  assign tlim = s_q.dyn ? dy_discharge_time_limit
                        : st_discharge_time_limit;
  assign clim = s_q.dyn ? dy_discharge_capacity_limit
                        : st_discharge_capacity_limit;
  assign tact = s_q.dyn ? dy_time_act : st_time_act;
  assign cact = s_q.dyn ? dy_cap_act : st_cap_act;
  // larger setting always becomes the pulse level
  assign hi_cur = (dy_current_a >= dy_current_b) ? dy_current_a
                                                 : dy_current_b;
  assign lo_cur = (dy_current_a >= dy_current_b) ? dy_current_b
                                                 : dy_current_a;
  // interval in ms from code
  always_comb begin
    if (log_interval == LOG_5S_CODE) begin
      log_ms = 14'd5000;
    end else if (log_interval == LOG_10S_CODE) begin
      log_ms = 14'd10000;
    end else if (log_interval > 4'h9) begin
      log_ms = 14'd1000;
    end else begin
      log_ms = 14'(({10'h0, log_interval} + 14'h1) * 14'(LOG_STEP_MS));
    end
  end

  // ==========================================================
  // regulation outputs
  assign load_on        = (s_q.st == ST_RUN);
  assign set_current    = !s_q.dyn ? st_current_max
                        : (s_q.hi ? hi_cur : lo_cur);
  assign set_power      = s_q.dyn ? dy_power_max : st_power_max;
  assign res_reg_en     = !s_q.dyn && (st_resistance != RES_OFF);
  assign set_resistance = res_reg_en ? st_resistance : RES_OFF;
  // regulation mode follows whichever static limit binds; dynamic runs always show CC
  always_comb begin
    if (s_q.st != ST_RUN) begin
      reg_mode = BTSEQ_REG_OFF;
    end else if (!s_q.dyn && meas_power >= st_power_max) begin
      reg_mode = BTSEQ_REG_CP;
    end else if (res_reg_en && meas_current < set_current) begin
      reg_mode = BTSEQ_REG_CR;
    end else begin
      reg_mode = BTSEQ_REG_CC;
    end
  end
  assign running        = (s_q.st == ST_RUN);
  assign time_limit_msg = s_q.tmsg;
  assign cap_limit_msg  = s_q.cmsg;
  assign stop_cause     = s_q.why;
  assign locked_out     = s_q.lock;
  assign elapsed_ms     = s_q.ms;
  assign used_mah_s     = s_q.mah_pub[31:0];
  assign used_wh_s      = s_q.wh_pub;
  assign disp_voltage   = meas_voltage;
  assign disp_threshold = thr;
  assign log_ready      = s_q.logged && (s_q.st == ST_IDLE);

  // ==========================================================
  // record words: header row and data row; data stamp kept to 31 bits
  always_comb begin
    rec_word = '0;
    if (s_q.st == ST_HDR) begin
      rec_word = RW'({REC_HEADER, s_q.dyn, set_current, set_power,
                      set_resistance, thr, tlim, clim});
    end else begin
      rec_word = RW'({REC_DATA, meas_voltage, meas_current,
                      meas_power, s_q.mah_pub[23:0], s_q.wh_pub[23:0],
                      s_q.ms[30:0]});
    end
  end

  // ==========================================================
  // sequencer
  always_comb begin
    logic tick_ms;
    logic tick_s;
    logic stop_now;
    logic auto_stop;
    btseq_why_t why;
    s_d = s_q;
    push = 1'b0;
    tick_ms = 1'b0;
    tick_s = 1'b0;
    stop_now = 1'b0;
    auto_stop = 1'b0;
    why = BTSEQ_STOP_NONE;
    // three-stage pin sync, change taken when stages 2 and 3 agree
    s_d.start_s = {s_q.start_s[1:0], start_pin};
    s_d.stop_s  = {s_q.stop_s[1:0], stop_pin};
    if (s_q.start_s[1] == s_q.start_s[2]) begin
      s_d.start_f = s_q.start_s[2];
    end
    if (s_q.stop_s[1] == s_q.stop_s[2]) begin
      s_d.stop_f = s_q.stop_s[2];
    end
    if (config_done) begin
      s_d.lock = 1'b0;
    end
    unique case (s_q.st)
      ST_IDLE: begin
        // rising start, refused while locked out
        if (s_d.start_f && !s_q.start_f && !s_q.lock && !s_d.stop_f) begin
          s_d.dyn = dyn_mode;
          s_d.hi = 1'b1;
          s_d.phase_s = '0;
          s_d.ms_cnt = '0;
          s_d.ms_in_s = '0;
          s_d.ms = '0;
          s_d.secs = '0;
          s_d.mah_s = '0;
          s_d.wh_s = '0;
          s_d.mah_pub = '0;
          s_d.wh_pub = '0;
          s_d.log_cnt = '0;
          s_d.tmsg = 1'b0;
          s_d.cmsg = 1'b0;
          s_d.logged = log_en;
          s_d.why = BTSEQ_STOP_NONE;
          s_d.st = log_en ? ST_HDR : ST_RUN;
        end
      end
      ST_HDR: begin
        // a stalled consumer must not block a manual stop
        push = !s_q.stop_f;
        if (s_q.stop_f || push_ok) begin
          s_d.st = s_q.stop_f ? ST_IDLE : ST_RUN;
        end
      end
      ST_RUN: begin
        if (s_q.ms_cnt == 26'(MS_N - 1)) begin
          s_d.ms_cnt = '0;
          tick_ms = 1'b1;
        end else begin
          s_d.ms_cnt = s_q.ms_cnt + 26'h1;
        end
        if (tick_ms) begin
          s_d.ms = s_q.ms + 32'h1;
          // integrate every ms; publish once per second
          s_d.mah_s = s_q.mah_s + 49'(meas_current);
          s_d.wh_s  = s_q.wh_s + 32'(meas_power);
          if (s_q.ms_in_s == 10'(MS_PER_S - 1)) begin
            s_d.ms_in_s = '0;
            tick_s = 1'b1;
          end else begin
            s_d.ms_in_s = s_q.ms_in_s + 10'h1;
          end
        end
        if (tick_s) begin
          s_d.secs = s_q.secs + 32'h1;
          s_d.mah_pub = s_d.mah_s;
          s_d.wh_pub = s_d.wh_s;
          // pulse and pause phases counted in whole seconds
          if (s_q.dyn) begin
            if (32'(s_q.phase_s) + 32'h1 >=
                32'(s_q.hi ? dy_pulse_s : dy_pause_s)) begin
              s_d.phase_s = '0;
              s_d.hi = ~s_q.hi;
            end else begin
              s_d.phase_s = s_q.phase_s + 16'h1;
            end
          end
        end
        // log pacing; a record is skipped only if buffer is full
        if (s_q.logged && tick_ms) begin
          if (s_q.log_cnt + 14'h1 >= log_ms) begin
            s_d.log_cnt = '0;
            push = 1'b1;
          end else begin
            s_d.log_cnt = s_q.log_cnt + 14'h1;
          end
        end
        // limit checks; 0.01 Ah = 36000000 mA*ms
        if (tlim != '0 && s_q.secs >= 32'(tlim)) begin
          if (tact == BTSEQ_ACT_SIGNAL) s_d.tmsg = 1'b1;
          if (tact == BTSEQ_ACT_END) begin
            auto_stop = 1'b1;
            why = BTSEQ_STOP_TIME;
          end
        end
        if (clim != '0 && 64'(s_q.mah_pub) >=
            64'(clim) * 64'd36_000_000) begin
          if (cact == BTSEQ_ACT_SIGNAL) s_d.cmsg = 1'b1;
          if (cact == BTSEQ_ACT_END) begin
            auto_stop = 1'b1;
            why = BTSEQ_STOP_CAP;
          end
        end
        if (meas_voltage <= thr) begin
          auto_stop = 1'b1;
          why = BTSEQ_STOP_VOLT;
        end
        if (input_off_alarm || over_temperature_alarm) begin
          auto_stop = 1'b1;
          why = BTSEQ_STOP_ALARM;
        end
        if (s_q.stop_f) begin
          stop_now = 1'b1;
          why = BTSEQ_STOP_MANUAL;
        end
        if (stop_now || auto_stop) begin
          s_d.st = ST_IDLE;
          s_d.why = why;
          s_d.lock = auto_stop && !stop_now;
        end
      end
      default: s_d.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // record buffer absorbs consumer stalls
  btseq_skid #(.W(RW)) u_buf (
    .mclk      (mclk),
    .nrst      (nrst),
    .ce        (ce),
    .in_valid  (push),
    .in_ready  (push_ok),
    .in_data   (rec_word),
    .out_valid (rec_valid),
    .out_ready (rec_ready),
    .out_data  (rec_data)
  );
endmodule // btseq_top

// File: tb/btseq_batt.sv
// Battery model: sags one step per ms under load, draws what is set.
// Assumes the sequencer clock and a shortened ms tick of MS_N cycles.
`timescale 1ns/100ps
module btseq_batt
  import btseq_pkg::*;
#(
  parameter int MS_N = 4
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        nrst,
  // load side
  input  wire logic        load_on,
  input  wire logic [15:0] set_current,
  input  wire logic [15:0] set_power,
  // measurements
  output logic [15:0]      meas_voltage,
  output logic [15:0]      meas_current,
  output logic [15:0]      meas_power
);
  // ==========================================================
  // rests at full charge when idle, so each run starts the same
  int cnt_q;
  always_ff @(posedge mclk) begin
    if (!nrst || !load_on) begin
      cnt_q        <= 0;
      meas_voltage <= 16'h0fa0;
    end else begin
      cnt_q <= (cnt_q == MS_N - 1) ? 0 : cnt_q + 1;
      if (cnt_q == MS_N - 1) begin
        meas_voltage <= meas_voltage - 16'h0001;
      end
    end
  end
  // ideal sink: no lag between setting and draw
  assign meas_current = load_on ? set_current : 16'h0000;
  assign meas_power   = load_on ? set_power : 16'h0000;
endmodule // btseq_batt

// File: tb/btseq_top_props.sv
// Checker for the battery test sequencer, bound to its top module.
// Assumes the bench holds mode and settings steady during a run.
`timescale 1ns/100ps
module btseq_top_props
  import btseq_pkg::*;
#(
  parameter int          IW   = 16,
  parameter int unsigned MS_N = MS_CYCLES,
  parameter int          RW   = 128
) (
  // clock and reset
  input wire logic          mclk,
  input wire logic          nrst,
  // controls and inputs
  input wire logic          stop_pin,
  input wire logic          config_done,
  input wire logic          dyn_mode,
  input wire logic [15:0]   st_resistance,
  input wire logic [IW-1:0] dy_current_a,
  input wire logic [IW-1:0] dy_current_b,
  input wire logic [IW-1:0] meas_voltage,
  input wire logic          input_off_alarm,
  input wire logic          over_temperature_alarm,
  // outputs watched, plus the rec_ready input
  input wire logic          load_on,
  input wire logic [IW-1:0] set_current,
  input wire logic          res_reg_en,
  input wire btseq_reg_t    reg_mode,
  input wire logic          running,
  input wire logic          locked_out,
  input wire logic [31:0]   used_mah_s,
  input wire logic [IW-1:0] disp_threshold,
  input wire logic          log_ready,
  input wire logic          rec_valid,
  input wire logic          rec_ready,
  input wire logic [RW-1:0] rec_data
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // ==========================================================
  // cycles since the charge total last moved
  int gap_q;
  always_ff @(posedge mclk) begin
    gap_q <= (!nrst || used_mah_s != $past(used_mah_s)) ? 0 : gap_q + 1;
  end
  sequence s_halt;
    ##[1:8] !running;
  endsequence
  // ==========================================================
  stop_ends_a: assert property ($rose(stop_pin) && running |-> s_halt)
    else $error("run kept going after stop");
  alarm_ends_a: assert property ((over_temperature_alarm ||
    input_off_alarm) && running |-> s_halt) else $error("alarm ignored");
  volt_ends_a: assert property (
    running && meas_voltage <= disp_threshold |-> s_halt)
    else $error("voltage threshold ignored");
  lock_hold_a: assert property (
    locked_out && !config_done |=> !$rose(running))
    else $error("restart while locked");
  load_follow_a: assert property (load_on &&
    (over_temperature_alarm || input_off_alarm) |=> !load_on)
    else $error("load kept on in alarm");
  idle_off_a: assert property (!running |-> reg_mode == BTSEQ_REG_OFF)
    else $error("regulation shown while idle");
  dyn_level_a: assert property (running && dyn_mode |->
    set_current == ((dy_current_a > dy_current_b) ? dy_current_a
    : dy_current_b) || set_current == ((dy_current_a > dy_current_b)
    ? dy_current_b : dy_current_a)) else $error("bad pulse level");
  res_gate_a: assert property (running && !dyn_mode |->
    res_reg_en == (st_resistance != RES_OFF)) else $error("res gate");
  ah_pace_a: assert property (running && $past(running) &&
    used_mah_s != $past(used_mah_s) |-> gap_q >= 1000 * MS_N - 8)
    else $error("charge updated too often");
  rec_hold_a: assert property (rec_valid && !rec_ready |=>
    rec_valid && $stable(rec_data)) else $error("record lost in stall");
  log_after_a: assert property (log_ready |-> !running)
    else $error("log offered during run");
endmodule // btseq_top_props
bind btseq_top btseq_top_props #(.IW(IW), .MS_N(MS_N), .RW(RW)) u_props (.*);

// File: tb/btseq_top_test.sv
// Testbench for the battery test sequencer with a battery model.
// Assumes a shortened ms tick; all operator settings come from here.
`timescale 1ns/100ps
module btseq_top_test;
  import btseq_pkg::*;
  localparam int MSN = 4;
  localparam int SEC = 1000 * MSN;
  logic mclk, nrst, ce, start_pin, stop_pin, config_done, dyn_mode;
  logic log_en, input_off_alarm, over_temperature_alarm, rec_ready;
  logic [15:0] st_current_max, st_power_max, st_resistance, dy_current_a;
  logic [15:0] dy_current_b, dy_power_max, dy_pulse_s, dy_pause_s;
  logic [15:0] st_discharge_voltage_threshold, st_discharge_time_limit;
  logic [15:0] dy_discharge_voltage_threshold, dy_discharge_time_limit;
  logic [23:0] st_discharge_capacity_limit, dy_discharge_capacity_limit;
  btseq_act_t  st_time_act, st_cap_act, dy_time_act, dy_cap_act;
  logic [3:0]  log_interval;
  logic [15:0] meas_voltage, meas_current, meas_power, set_current;
  logic [15:0] set_power, set_resistance, disp_voltage, disp_threshold;
  logic        load_on, res_reg_en, running, time_limit_msg, cap_limit_msg;
  logic        locked_out, log_ready, rec_valid;
  btseq_reg_t  reg_mode;
  btseq_why_t  stop_cause;
  logic [31:0] elapsed_ms, used_mah_s, used_wh_s;
  logic [127:0] rec_data, first_rec;
  int          err_count, num_checks, n_rec;
  btseq_top #(.MS_N(MSN)) dut (.*);
  btseq_batt #(.MS_N(MSN)) u_batt (.*);
  // ==========================================================
  // clock, and a watchdog well past the expected run length
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    repeat (40000) @(posedge mclk);
    err_count++;
    finish_test();
  end
  // count handed-over records, keep the first
  always @(posedge mclk) begin
    if (rec_valid && rec_ready) begin
      if (n_rec == 0) first_rec = rec_data;
      n_rec++;
    end
  end
  // ==========================================================
  task automatic finish_test();
    if (err_count == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input bit ok, input string msg);
    num_checks++;
    if (!ok) begin
      err_count++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1; // step off the edge so outputs have settled
  endtask
  // pin held long enough to pass the input synchroniser
  task automatic pin_pulse(input bit stp);
    @(posedge mclk) if (stp) stop_pin <= 1'b1; else start_pin <= 1'b1;
    tick(6);
    @(posedge mclk) {start_pin, stop_pin} <= 2'b00;
  endtask
  task automatic begin_run(input bit cfg, input bit exp_run);
    if (cfg) begin
      @(posedge mclk) config_done <= 1'b1;
      @(posedge mclk) config_done <= 1'b0;
    end
    n_rec = 0;
    pin_pulse(1'b0);
    tick(8);
    chk(running === exp_run, "run state after start");
  endtask
  task automatic halt_wait(input int n, input btseq_why_t why, input bit lk);
    for (int i = 0; i < n && running !== 1'b0; i++) @(posedge mclk);
    tick(2);
    chk(running === 1'b0 && stop_cause === why && locked_out === lk,
        "stop cause or lockout");
  endtask
  // ==========================================================
  initial begin
    {ce, nrst, start_pin, stop_pin, config_done, dyn_mode} = 6'h20;
    {log_en, log_interval, rec_ready} = 6'h20;
    {input_off_alarm, over_temperature_alarm} = 2'b00;
    {st_current_max, st_power_max} = {16'h4e20, 16'h0100};
    {st_resistance, dy_power_max} = {RES_OFF, 16'h0100};
    {dy_current_a, dy_current_b} = {16'h0064, 16'h012c};
    {dy_pulse_s, dy_pause_s} = {16'h0001, 16'h0001};
    {st_discharge_voltage_threshold, st_discharge_time_limit} = 32'h1;
    {dy_discharge_voltage_threshold, dy_discharge_time_limit} = 32'h3;
    st_discharge_capacity_limit = 24'h000001;
    dy_discharge_capacity_limit = 24'h000000;
    {st_time_act, st_cap_act} = {BTSEQ_ACT_SIGNAL, BTSEQ_ACT_END};
    {dy_time_act, dy_cap_act} = {BTSEQ_ACT_END, BTSEQ_ACT_END};
    tick(16);
    nrst <= 1'b1;
    tick(4);
    // static run, receiver stalls first, stops on charge
    begin_run(1'b0, 1'b1);
    chk(set_current === 16'h4e20 && set_power === 16'h0100, "limits");
    chk(res_reg_en === 1'b0 && log_ready === 1'b0, "res off, no log");
    tick(300);
    rec_ready <= 1'b1;
    tick(SEC + SEC / 2 - 300);
    chk(used_mah_s >= 32'd19980000 && used_mah_s <= 32'd20000000, "ah");
    chk(used_wh_s >= 32'd255744 && used_wh_s <= 32'd256000, "wh");
    chk(time_limit_msg === 1'b1 && running === 1'b1, "signal");
    chk(n_rec >= 15 && n_rec <= 17, "record pace");
    chk(elapsed_ms >= 32'd1500 && elapsed_ms <= 32'd1505, "ms");
    chk(disp_voltage + elapsed_ms[15:0] == 16'h0fa0, "volt shown");
    chk(first_rec[105] === REC_HEADER && first_rec[23:0] === 24'h1, "hdr");
    halt_wait(SEC, BTSEQ_STOP_CAP, 1'b1);
    chk(log_ready === 1'b1, "log after stop");
    begin_run(1'b0, 1'b0);
    // dynamic run: own limits, pulse and pause of one second
    @(posedge mclk) dyn_mode <= 1'b1;
    begin_run(1'b1, 1'b1);
    tick(SEC / 2);
    chk(set_current === 16'h012c, "upper level first");
    tick(SEC);
    chk(set_current === 16'h0064, "lower level in pause");
    tick(SEC);
    chk(set_current === 16'h012c, "upper level again");
    chk(time_limit_msg === 1'b0 && running === 1'b1, "own limits");
    halt_wait(SEC, BTSEQ_STOP_TIME, 1'b1);
    // static run with resistance, stopped by the sagging battery
    @(posedge mclk) begin
      dyn_mode <= 1'b0;
      st_resistance <= 16'h0064;
      st_discharge_voltage_threshold <= 16'h0dac;
    end
    begin_run(1'b1, 1'b1);
    chk(res_reg_en === 1'b1 && set_resistance === 16'h0064, "res");
    halt_wait(SEC, BTSEQ_STOP_VOLT, 1'b1);
    @(posedge mclk) st_discharge_voltage_threshold <= 16'h0000;
    // both alarm kinds end the run
    for (int k = 0; k < 2; k++) begin
      begin_run(1'b1, 1'b1);
      @(posedge mclk) {input_off_alarm, over_temperature_alarm} <= 2'(k + 1);
      halt_wait(20, BTSEQ_STOP_ALARM, 1'b1);
      @(posedge mclk) {input_off_alarm, over_temperature_alarm} <= 2'b00;
    end
    // manual stop leaves no lockout
    begin_run(1'b1, 1'b1);
    pin_pulse(1'b1);
    halt_wait(20, BTSEQ_STOP_MANUAL, 1'b0);
    begin_run(1'b0, 1'b1);
    st_cap_act <= BTSEQ_ACT_SIGNAL;
    tick(2 * SEC + SEC / 4);
    chk(cap_limit_msg === 1'b1 && running === 1'b1, "cap signal");
    finish_test();
  end
endmodule // btseq_top_test
